/* File: rtl/atc_ctrl.sv */
// Host controller driving the step attenuator pins from Wishbone registers
`timescale 1ns/10ps
`include "atc_regs.svh"

module atc_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Attenuator pins
  output logic             mode_serial_o,
  output logic             latch_strobe_o,
  output logic             shift_clk_o,
  output logic             serial_data_o,
  output logic      [6:0]  parallel_attenuation_inputs_o
);

  // Reset image of the whole state
  localparam atc_pkg::atc_state_type RST_STATE = '{
    fsm:        atc_pkg::ST_IDLE,
    cnt:        8'h00,
    bitn:       4'h0,
    shreg:      16'h0000,
    pins:       '{ps: `ATC_RST_SERIAL, le: 1'b0, sclk: 1'b0, sdata: 1'b0, par: 7'h00},
    tgt_serial: `ATC_RST_SERIAL,
    latched:    `ATC_RST_LATCH,
    word:       `ATC_RST_WORD,
    addr:       `ATC_RST_ADDR,
    apply_req:  1'b0,
    init_done:  1'b0,
    ack:        1'b0,
    rdat:       32'h0000_0000
  };

  atc_pkg::atc_state_type q;       // Registered state
  atc_pkg::atc_state_type d;       // Next state
  logic                   bus_hit; // Fresh bus access
  logic                   bus_wr;  // Fresh bus write

  // Wait count loaded for a cycle figure
  function automatic logic [7:0] cyc_f(input int unsigned c);
    return 8'(c - 1);
  endfunction

  // Load a frame and begin shifting
  function automatic atc_pkg::atc_state_type start_frame_f(input atc_pkg::atc_state_type s);
    atc_pkg::atc_state_type r;
    r = s;
    r.shreg      = {`ATC_ADDR_PAD, r.addr, `ATC_SPARE_BIT, r.word};
    r.pins.sdata = r.shreg[0];
    r.pins.sclk  = 1'b0;
    r.pins.le    = 1'b0;
    r.bitn       = 4'h0;
    r.cnt        = cyc_f(`ATC_C_CLKL);
    r.fsm        = atc_pkg::ST_SH_LO;
    return r;
  endfunction

  // Present the word on the parallel pins
  function automatic atc_pkg::atc_state_type start_par_f(input atc_pkg::atc_state_type s);
    atc_pkg::atc_state_type r;
    r = s;
    r.pins.par = r.word;
    if (r.latched) begin
      r.pins.le = 1'b0;
      r.cnt     = cyc_f(`ATC_C_DISU);
      r.fsm     = atc_pkg::ST_PAR_SU;
    end else begin
      r.pins.le = 1'b1;
      r.cnt     = cyc_f(`ATC_C_DIH);
      r.fsm     = atc_pkg::ST_HOLD;
    end
    return r;
  endfunction

  // Send the setting in the current mode
  function automatic atc_pkg::atc_state_type apply_f(input atc_pkg::atc_state_type s);
    if (s.pins.ps) begin
      return start_frame_f(s);
    end
    return start_par_f(s);
  endfunction

  // Next-state logic: sequencer first, bus writes after so a set wins
  always_comb begin
    d       = q;
    bus_hit = wb_cyc_i && wb_stb_i && !q.ack;
    bus_wr  = bus_hit && wb_we_i;
    d.ack   = 1'b0;

    // Count down any pending wait
    if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end else begin
      case (q.fsm)
        // Waiting for work
        atc_pkg::ST_IDLE: begin
          if (q.tgt_serial != q.pins.ps) begin
            if (!q.tgt_serial && !q.init_done) begin
              d = start_frame_f(d);
            end else begin
              d.pins.par = 7'h00;
              d.pins.le  = 1'b0;
              d.cnt      = cyc_f(`ATC_C_PSSU);
              d.fsm      = atc_pkg::ST_PS_SU;
            end
          end else if (q.apply_req) begin
            d.apply_req = 1'b0;
            d           = apply_f(d);
          end
        end
        // Inputs settled, flip mode select
        atc_pkg::ST_PS_SU: begin
          d.pins.ps = q.tgt_serial;
          d.cnt     = cyc_f(`ATC_C_PSH);
          d.fsm     = atc_pkg::ST_PS_H;
        end
        // Mode held, send setting in new mode
        atc_pkg::ST_PS_H: begin
          // later switches run the same path
          d.apply_req = 1'b0;
          d           = apply_f(d);
        end
        // Shift clock low phase done
        atc_pkg::ST_SH_LO: begin
          d.pins.sclk = 1'b1;
          d.cnt       = cyc_f(`ATC_C_CLKH);
          d.fsm       = atc_pkg::ST_SH_HI;
        end
        // Shift clock high phase done
        atc_pkg::ST_SH_HI: begin
          d.pins.sclk = 1'b0;
          if (q.bitn == `ATC_FRAME_LAST) begin
            d.cnt = cyc_f(`ATC_C_LESU);
            d.fsm = atc_pkg::ST_LE_SU;
          end else begin
            d.shreg      = q.shreg >> 1;
            d.pins.sdata = q.shreg[1];
            d.bitn       = 4'(q.bitn + 4'h1);
            d.cnt        = cyc_f(`ATC_C_CLKL);
            d.fsm        = atc_pkg::ST_SH_LO;
          end
        end
        // Last edge to strobe setup done
        atc_pkg::ST_LE_SU: begin
          d.pins.le = 1'b1;
          d.cnt     = cyc_f(`ATC_C_LEPW);
          d.fsm     = atc_pkg::ST_LE_HI;
        end
        // Serial strobe pulse done
        atc_pkg::ST_LE_HI: begin
          d.pins.le   = 1'b0;
          d.init_done = 1'b1;
          d.cnt       = cyc_f(`ATC_C_DIH);
          d.fsm       = atc_pkg::ST_HOLD;
        end
        // Parallel data setup done
        atc_pkg::ST_PAR_SU: begin
          d.pins.le = 1'b1;
          d.cnt     = cyc_f(`ATC_C_LEPW);
          d.fsm     = atc_pkg::ST_PAR_LE;
        end
        // Parallel strobe pulse done
        atc_pkg::ST_PAR_LE: begin
          d.pins.le = 1'b0;
          d.cnt     = cyc_f(`ATC_C_DIH);
          d.fsm     = atc_pkg::ST_HOLD;
        end
        atc_pkg::ST_HOLD: begin
          d.fsm = atc_pkg::ST_IDLE;
        end
        // Recover from an illegal state
        default: begin
          d.fsm = atc_pkg::ST_IDLE;
        end
      endcase
    end

    // Register access, answered one cycle after the request
    if (bus_hit) begin
      d.ack = 1'b1;
      case (wb_adr_i)
        // Mode and latch option
        `ATC_ADR_CTRL: begin
          d.rdat = {30'h0, q.latched, q.tgt_serial};
          if (bus_wr && wb_sel_i[0]) begin
            d.tgt_serial = wb_dat_i[`ATC_CTRL_SERIAL];
            d.latched    = wb_dat_i[`ATC_CTRL_LATCH];
            d.apply_req  = 1'b1;
          end
        end
        // Attenuation word and address
        `ATC_ADR_ATTEN: begin
          d.rdat = {21'h0, q.addr, 1'b0, q.word};
          if (bus_wr && wb_sel_i[0]) begin
            d.word = wb_dat_i[`ATC_ATT_WORD_MSB:`ATC_ATT_WORD_LSB];
          end
          if (bus_wr && wb_sel_i[1]) begin
            d.addr = wb_dat_i[`ATC_ATT_ADDR_MSB:`ATC_ATT_ADDR_LSB];
          end
          if (bus_wr && (wb_sel_i[0] || wb_sel_i[1])) begin
            d.apply_req = 1'b1;
          end
        end
        // Status, read only
        `ATC_ADR_STAT: begin
          d.rdat = {28'h0, q.pins.le, q.pins.ps, q.init_done,
                    (q.fsm != atc_pkg::ST_IDLE) || q.apply_req
                    || (q.tgt_serial != q.pins.ps)};
        end
        // Unmapped offsets read zero
        default: begin
          d.rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o                      = q.rdat;
  assign wb_ack_o                      = q.ack;
  assign mode_serial_o                 = q.pins.ps;
  assign latch_strobe_o                = q.pins.le;
  assign shift_clk_o                   = q.pins.sclk;
  assign serial_data_o                 = q.pins.sdata;
  assign parallel_attenuation_inputs_o = q.pins.par;

endmodule

/* File: rtl/atc_regs.svh */
// Constants of the attenuator controller: timing, register map, fields, resets
// Notes on behaviour
// - Serial start-up keeps parallel inputs low.
// - Serial frame clears D7 before first parallel switch.
// - Parallel start-up zeroes inputs before serial, until frame.
// - Ordering applies once; afterwards switching is free.
// - Latched parallel: strobe low while word changes.
// - Strobe pulse high then low captures word.
// - Strobe back low before next word.
// - Sixteen-bit frame, LSB first, attenuation then address.
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// System clock period
`define ATC_CLK_NS 8

// Link timing minima in nanoseconds
`define ATC_T_CLKH_NS 30
`define ATC_T_CLKL_NS 80
`define ATC_T_LESU_NS 10
`define ATC_T_LEPW_NS 30
`define ATC_T_DISU_NS 100
`define ATC_T_DIH_NS 100
`define ATC_T_PSSU_NS 100
`define ATC_T_PSH_NS 100

// Minima rounded up to whole clock cycles
`define ATC_CYC(ns) (((ns) + `ATC_CLK_NS - 1) / `ATC_CLK_NS)
`define ATC_C_CLKH `ATC_CYC(`ATC_T_CLKH_NS)
`define ATC_C_CLKL `ATC_CYC(`ATC_T_CLKL_NS)
`define ATC_C_LESU `ATC_CYC(`ATC_T_LESU_NS)
`define ATC_C_LEPW `ATC_CYC(`ATC_T_LEPW_NS)
`define ATC_C_DISU `ATC_CYC(`ATC_T_DISU_NS)
`define ATC_C_DIH `ATC_CYC(`ATC_T_DIH_NS)
`define ATC_C_PSSU `ATC_CYC(`ATC_T_PSSU_NS)
`define ATC_C_PSH `ATC_CYC(`ATC_T_PSH_NS)

// Frame layout
`define ATC_FRAME_LAST 4'hF
`define ATC_ADDR_PAD 5'h00
`define ATC_SPARE_BIT 1'b0

// Register byte offsets
`define ATC_ADR_CTRL 4'h0
`define ATC_ADR_ATTEN 4'h4
`define ATC_ADR_STAT 4'h8

// Field positions
`define ATC_CTRL_SERIAL 0
`define ATC_CTRL_LATCH 1
`define ATC_ATT_WORD_LSB 0
`define ATC_ATT_WORD_MSB 6
`define ATC_ATT_ADDR_LSB 8
`define ATC_ATT_ADDR_MSB 10

// Reset values
`define ATC_RST_SERIAL 1'b1
`define ATC_RST_LATCH 1'b0
`define ATC_RST_WORD 7'h7F
`define ATC_RST_ADDR 3'h0

`endif

/* File: rtl/atc_pkg.sv */
// Types shared by the attenuator controller
package atc_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_PS_SU,
    ST_PS_H,
    ST_SH_LO,
    ST_SH_HI,
    ST_LE_SU,
    ST_LE_HI,
    ST_PAR_SU,
    ST_PAR_LE,
    ST_HOLD
  } atc_fsm_type;

  // Pins driven toward the attenuator
  typedef struct packed {
    logic       ps;     // Mode select, high for serial
    logic       le;     // Latch strobe
    logic       sclk;   // Shift clock
    logic       sdata;  // Serial data
    logic [6:0] par;    // Parallel attenuation inputs
  } atc_pins_type;

  // Whole controller state
  typedef struct packed {
    atc_fsm_type  fsm;         // Sequencer state
    logic [7:0]   cnt;         // Wait counter
    logic [3:0]   bitn;        // Frame bit index
    logic [15:0]  shreg;       // Outgoing frame
    atc_pins_type pins;        // Pin levels
    logic         tgt_serial;  // Requested mode
    logic         latched;     // Latched parallel option
    logic [6:0]   word;        // Attenuation word
    logic [2:0]   addr;        // Target serial address
    logic         apply_req;   // Setting waits to be sent
    logic         init_done;   // Spare bit cleared once
    logic         ack;         // Bus acknowledge
    logic [31:0]  rdat;        // Bus read data
  } atc_state_type;

endpackage

/* File: sim/atc_ctrl_checker.sv */
// Assertion checker for the attenuator controller pins and bus
`timescale 1ns/10ps
module atc_ctrl_checker (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Attenuator pins
  input wire logic       mode_serial_o,
  input wire logic       latch_strobe_o,
  input wire logic       shift_clk_o,
  input wire logic       serial_data_o,
  input wire logic [6:0] parallel_attenuation_inputs_o
);
  logic [4:0] nbit_q;  // Shift edges since last strobe
  logic       sclk_q;  // Shift clock one cycle back
  logic       sent_q;  // A full frame was latched

  // Counts shift edges and notes latched frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nbit_q <= 5'h00;
      sclk_q <= 1'b0;
      sent_q <= 1'b0;
    end else begin
      sclk_q <= shift_clk_o;
      if (latch_strobe_o) begin
        nbit_q <= 5'h00;
      end else if (shift_clk_o && !sclk_q) begin
        nbit_q <= nbit_q + 5'h01;
      end
      if (latch_strobe_o && mode_serial_o && nbit_q == 5'h10) begin
        sent_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_clk_high;
    shift_clk_o [*4] ##1 !shift_clk_o;
  endsequence
  sequence s_strobe_pulse;
    latch_strobe_o [*4] ##1 !latch_strobe_o;
  endsequence

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_serial_par_low: assert property (mode_serial_o |-> parallel_attenuation_inputs_o == 7'h00)
    else $error("parallel pins high in serial mode");
  a_enter_zeroed: assert property ($rose(mode_serial_o) |-> $past(parallel_attenuation_inputs_o, 8) == 7'h00)
    else $error("serial entered without zeroed pins");
  a_first_leave: assert property ($fell(mode_serial_o) |-> sent_q)
    else $error("parallel selected before a frame");
  a_shift_strobe_low: assert property ($rose(shift_clk_o) |-> !latch_strobe_o)
    else $error("shift edge with strobe high");
  a_clk_high_time: assert property ($rose(shift_clk_o) |-> s_clk_high)
    else $error("shift clock high phase wrong");
  a_data_stable: assert property (shift_clk_o |-> $stable(serial_data_o))
    else $error("serial data moved while clock high");
  a_frame_len: assert property ($rose(latch_strobe_o) && mode_serial_o |-> (nbit_q == 5'h10) ##0 s_strobe_pulse)
    else $error("frame not sixteen bits or bad strobe");
  a_strobe_setup: assert property ($rose(latch_strobe_o) && mode_serial_o |-> !$past(shift_clk_o) && !$past(shift_clk_o, 2))
    else $error("strobe too soon after last shift edge");
endmodule

bind atc_ctrl atc_ctrl_checker i_atc_ctrl_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .mode_serial_o, .latch_strobe_o, .shift_clk_o, .serial_data_o,
  .parallel_attenuation_inputs_o);

/* File: sim/atc_dev_model.sv */
// Behavioural model of the step attenuator control logic
`timescale 1ns/10ps
module atc_dev_model #(
  parameter logic [2:0] STRAP_ADDR = 3'h0  // Straps left open
) (
  // Control pins from the controller
  input  wire logic       mode_serial_i,
  input  wire logic       latch_strobe_i,
  input  wire logic       shift_clk_i,
  input  wire logic       serial_data_i,
  input  wire logic [6:0] parallel_attenuation_inputs_i,
  // Observed state
  output logic      [6:0] setting_o = 7'h7F,
  output logic            fault_o
);
  logic [15:0] shreg = 16'h0000;  // Serial shift register
  logic        spare = 1'b1;      // Spare bit, high until cleared
  logic        moved = 1'b0;      // First mode change done
  logic        pin_fault = 1'b0;  // Parallel pins high in serial mode
  logic        seq_fault = 1'b0;  // First switch before spare cleared

  // One driver for the reported fault
  assign fault_o = pin_fault | seq_fault;

  always @(posedge shift_clk_i) begin
    if (!latch_strobe_i) begin
      shreg <= {serial_data_i, shreg[15:1]};
    end
  end

  // transfer while strobe high, no delay
  always @* begin
    if (latch_strobe_i && mode_serial_i && shreg[10:8] == STRAP_ADDR) begin
      setting_o = shreg[6:0];
      spare = shreg[7];
    end else if (latch_strobe_i && !mode_serial_i) begin
      setting_o = parallel_attenuation_inputs_i;
    end
  end

  always @* begin
    if (mode_serial_i && parallel_attenuation_inputs_i != 7'h00) begin
      pin_fault = 1'b1;
    end
  end

  // only first switch to parallel needs spare cleared
  always @(negedge mode_serial_i) begin
    if (!moved && spare) begin
      seq_fault = 1'b1;
    end
    moved = 1'b1;
  end
endmodule

/* File: sim/atc_ctrl_tb_top.sv */
// Self-checking bench for the attenuator controller
`timescale 1ns/10ps
module atc_ctrl_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, mode_serial_o, latch_strobe_o, shift_clk_o, serial_data_o;
  logic [6:0]  parallel_attenuation_inputs_o;
  logic [6:0]  setting;   // Device attenuation
  logic        fault;     // Device pin or order fault
  logic [31:0] rd;        // Last read data
  int          miscompares = 0;
  int          checks_done = 0;
  // Row: control, attenuation register, expected setting
  typedef struct packed {logic [7:0] ctrl; logic [15:0] atten; logic [6:0] exp;} atc_row_type;
  atc_row_type rows [6] = '{'{8'h01, 16'h002A, 7'h2A}, '{8'h01, 16'h0515, 7'h2A},
    '{8'h02, 16'h0055, 7'h55}, '{8'h00, 16'h000F, 7'h0F}, '{8'h01, 16'h00FF, 7'h7F},
    '{8'h02, 16'h0001, 7'h01}};

  atc_ctrl i_atc_ctrl (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .mode_serial_o, .latch_strobe_o, .shift_clk_o,
    .serial_data_o, .parallel_attenuation_inputs_o);
  atc_dev_model i_atc_dev_model (.mode_serial_i(mode_serial_o), .latch_strobe_i(latch_strobe_o),
    .shift_clk_i(shift_clk_o), .serial_data_i(serial_data_o),
    .parallel_attenuation_inputs_i(parallel_attenuation_inputs_o), .setting_o(setting),
    .fault_o(fault));

  // Clock, 8 ns period
  always #4 clk_i = ~clk_i;

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One classic Wishbone access
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin chk(0, 1, "ack timeout"); end_of_test(); end
  endtask

  // Poll status until the sequencer is idle
  task automatic wait_idle;
    int n = 0;
    repeat (3) @(posedge clk_i);
    do begin wb(1'b0, 4'h8, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 300);
    if (n >= 300) begin chk(0, 1, "busy timeout"); end_of_test(); end
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({wb_ack_o, mode_serial_o, latch_strobe_o, shift_clk_o, serial_data_o,
      parallel_attenuation_inputs_o}, {5'b01000, 7'h00}, "reset pins");
    foreach (rows[i]) begin
      wb(1'b1, 4'h4, {16'h0, rows[i].atten});
      wb(1'b1, 4'h0, {24'h0, rows[i].ctrl});
      wait_idle();
      chk(setting, rows[i].exp, "setting");
      chk(fault, 1'b0, "mode order");
      chk(rd, {28'h0, rows[i].ctrl[1:0] == 2'b00, rows[i].ctrl[0], 2'b10}, "status");
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, {21'h0, rows[i].atten[10:8], 1'b0, rows[i].atten[6:0]}, "atten reg");
    end
    wb(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    // Reset in the middle of the frame that follows a mode change
    wb(1'b1, 4'h0, 32'h1);
    repeat (40) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({wb_ack_o, mode_serial_o, latch_strobe_o, shift_clk_o, serial_data_o,
      parallel_attenuation_inputs_o}, {5'b01000, 7'h00}, "mid reset pins");
    wb(1'b0, 4'h8, 32'h0);
    chk(rd[1], 1'b0, "init flag after reset");
    // First switch to parallel after reset goes through a frame
    wb(1'b1, 4'h4, 32'h0044);
    wb(1'b1, 4'h0, 32'h0);
    wait_idle();
    chk(setting, 7'h44, "direct after reset");
    chk(fault, 1'b0, "order after reset");
    chk(rd[3:0], 4'hA, "status after reset");
    end_of_test();
  end
endmodule
